//--- rtl/float_unit_pkg.sv
// package: widths, field layout, special patterns and opcodes of the float unit
package float_unit_pkg;
  localparam int WORD_W         = 60;  // operand and result word
  localparam int COEF_W         = 48;  // coefficient field
  localparam int EXP_W          = 11;  // exponent field
  localparam int INDEX_W        = 18;  // index register width
  localparam int SIGN_POS       = 59;  // coefficient sign bit
  localparam int EXP_MSB        = 58;  // top of exponent field
  localparam int EXP_LSB        = 48;  // bottom of exponent field
  localparam int NORM_POS       = 47;  // must differ from sign when normalized
  localparam int EXP_SIGN_POS   = 10;  // exponent field sign, flipped by bias
  localparam int TOP_W          = 12;  // sign plus exponent field
  localparam int SUM_MSB        = 98;  // 96-bit result plus sign and guard
  localparam int HALF_W         = 48;  // half of the 96-bit result
  localparam int DOUBLE_EXP_ADJ = 48;  // lower half weight for double sum
  localparam int MAX_NORM_SHIFT = 48;  // zero coefficient shifts this far
  localparam int RESULT_LATENCY = 1;   // issue edge to result edge

  // top twelve bits of infinite and indefinite operands
  localparam logic [11:0] TOP_INF_POS   = 12'h7FF;
  localparam logic [11:0] TOP_INF_NEG   = 12'h800;
  localparam logic [11:0] TOP_INDEF_POS = 12'h3FF;
  localparam logic [11:0] TOP_INDEF_NEG = 12'hC00;

  // reset values of the result holding registers
  localparam logic [59:0] DEST_RESET  = 60'h000000000000000;
  localparam logic [17:0] INDEX_RESET = 18'h00000;

  // operation codes, octal 25 through 32
  typedef enum logic [5:0] {
    OP_ROUND_NORM  = 6'h15,
    OP_UNPACK      = 6'h16,
    OP_PACK        = 6'h17,
    OP_FLOAT_SUM   = 6'h18,
    OP_FLOAT_DIFF  = 6'h19,
    OP_DOUBLE_SUM  = 6'h1A
  } opcode_t;

  // whole state of the top module
  typedef struct packed {
    logic        resultValid;
    logic [59:0] destWord;
    logic [17:0] indexCount;
    logic        indexWrite;
    logic        infiniteExit;
    logic        indefiniteExit;
  } unit_state_t;
endpackage

//--- rtl/unpack_if.sv
// interface: one operand word and its unpacked parts
`timescale 1ns/1ps
interface unpack_if import float_unit_pkg::*; ();
  logic [59:0]        word;      // packed floating operand
  logic               sign;      // coefficient sign
  logic signed [49:0] coef;      // coefficient, two's complement
  logic [10:0]        expOnes;   // exponent, ones complement, unbiased
  logic signed [11:0] expo;      // exponent, two's complement
  logic               isInf;     // infinite pattern
  logic               isIndef;   // indefinite pattern

  modport unpacker (input word, output sign, coef, expOnes, expo, isInf, isIndef);
  modport consumer (output word, input sign, coef, expOnes, expo, isInf, isIndef);
endinterface

//--- rtl/float_unpacker.sv
// module: splits one floating word into sign, coefficient and exponent
`timescale 1ns/1ps
module float_unpacker import float_unit_pkg::*; (
  unpack_if.unpacker port
);
  logic [10:0] field;  // exponent field with sign effect removed
  logic [11:0] top;    // sign plus raw exponent field

  // purely combinational; both operands share this decode
  always_comb begin
    port.sign = port.word[SIGN_POS];
    // negative coefficient complements the whole field
    field = port.word[EXP_MSB:EXP_LSB] ^ {EXP_W{port.sign}};
    // bias is the flipped top bit of the field
    port.expOnes = {~field[EXP_SIGN_POS], field[9:0]};
    // ones complement to two's: negative values gain one
    if (port.expOnes[EXP_SIGN_POS]) begin
      port.expo = $signed({1'b1, port.expOnes}) + 12'sh001;
    end else begin
      port.expo = $signed({1'b0, port.expOnes});
    end
    // ones complement coefficient to two's complement
    port.coef = $signed({port.sign, port.sign, port.word[47:0]})
              + $signed({49'h0, port.sign});
    top = port.word[59:48];
    port.isInf   = (top == TOP_INF_POS) || (top == TOP_INF_NEG);
    port.isIndef = (top == TOP_INDEF_POS) || (top == TOP_INDEF_NEG);
  end
endmodule

//--- rtl/float_unit.sv
// top: round-normalize, unpack, pack and floating sum/difference unit
`timescale 1ns/1ps
//
// Contract
// - round bit is inverted sign below LSB
// - shift until bit 47 differs from 59
// - round bit travels with shifted coefficient
// - exponent drops by shift count
// - shift count goes to index register
// - special operand: copy word, zero index
// - special operand raises matching exit flag
// - unpack coefficient sign-extended from sign
// - unpack exponent unbiased, extended to 18
// - pack copies low 48 bits, sign
// - pack exponent from low 11 index bits
// - add/subtract accept unnormalized operands
// - align smaller exponent coefficient rightward
// - sum upper half with larger exponent
// - overflow shifts right, exponent plus one
// - difference subtracts second from first likewise
// - no normalization after add or subtract
// - double sum: lower half, exponent minus 48
// - special add operands raise exit flags
// - decode octal codes 25 through 32
module float_unit import float_unit_pkg::*; (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        issueValid,
  input  wire logic [5:0]  opCode,
  input  wire logic [59:0] firstSourceWord,
  input  wire logic [59:0] secondSourceWord,
  input  wire logic [17:0] indexSource,
  output logic             resultValid,
  output logic [59:0]      destWord,
  output logic [17:0]      indexCount,
  output logic             indexWrite,
  output logic             infiniteExit,
  output logic             indefiniteExit
);

  unit_state_t stReg;   // registered state
  unit_state_t stNext;  // next state

  // operand decode
  unpack_if jPort ();
  unpack_if kPort ();

  logic               issueNorm;    // round-normalize issued
  logic               issueUnpack;  // unpack issued
  logic               issuePack;    // pack issued
  logic               issueAdd;     // any of the three sums issued
  logic               kSpecial;     // second operand infinite/indefinite

  // round-normalize datapath
  logic [95:0]        normExt;      // coefficient, round bit, fill
  logic [95:0]        normShifted;  // after left shift
  logic [6:0]         normCount;    // shift count, 0..48
  logic               normFound;    // first differing bit seen
  logic signed [12:0] normExp;      // exponent after shift
  logic [59:0]        normWord;     // packed normalized result

  // floating add datapath
  logic signed [12:0] jExp;         // first exponent, widened
  logic signed [12:0] kExp;         // second exponent, widened
  logic               jLarger;      // first exponent not smaller
  logic signed [12:0] expMax;       // larger exponent
  logic [12:0]        expDiff;      // alignment distance
  logic signed [98:0] alignJ;       // first coefficient, upper half
  logic signed [98:0] alignK;       // second coefficient, upper half
  logic signed [98:0] shiftJ;       // first after alignment
  logic signed [98:0] shiftK;       // second after alignment
  logic signed [98:0] sumRaw;       // 96-bit result with guard
  logic               sumOverflow;  // result beyond 96 bits
  logic signed [98:0] sumAdj;       // after overflow correction
  logic signed [98:0] sumOnes;      // ones complement form
  logic signed [12:0] expRes;       // result exponent
  logic [59:0]        singleWord;   // upper half packed
  logic [59:0]        doubleWord;   // lower half packed

  // packs a sign, a two's exponent and a coefficient into a word
  function automatic logic [59:0] pack_word(
    input logic               sign,
    input logic signed [12:0] expo,
    input logic [47:0]        coef
  );
    logic [10:0] ones;
    logic [10:0] field;
    // two's to ones complement; out-of-range exponents wrap
    if (expo[12]) begin
      ones = 11'(expo - 13'sh0001);
    end else begin
      ones = expo[10:0];
    end
    // bias flips the top bit, negative sign complements all
    field = {~ones[EXP_SIGN_POS], ones[9:0]} ^ {EXP_W{sign}};
    return {sign, field, coef};
  endfunction

  assign jPort.word = firstSourceWord;
  assign kPort.word = secondSourceWord;

  // one decoder instance for each operand
  float_unpacker jUnpack (
    .port (jPort.unpacker)
  );
  float_unpacker kUnpack (
    .port (kPort.unpacker)
  );

  // opcode decode
  assign issueNorm   = issueValid && (opCode == OP_ROUND_NORM);
  assign issueUnpack = issueValid && (opCode == OP_UNPACK);
  assign issuePack   = issueValid && (opCode == OP_PACK);
  assign issueAdd    = issueValid && ((opCode == OP_FLOAT_SUM) ||
                       (opCode == OP_FLOAT_DIFF) || (opCode == OP_DOUBLE_SUM));
  assign kSpecial    = kPort.isInf || kPort.isIndef;

  // round-normalize: priority search for the leading significant bit
  always_comb begin
    // round bit below LSB, vacated bits filled with sign
    normExt = {secondSourceWord[47:0], ~kPort.sign, {47{kPort.sign}}};
    normCount = 7'(MAX_NORM_SHIFT);
    normFound = 1'b0;
    for (int i = 0; i <= MAX_NORM_SHIFT; i++) begin
      // fewest positions that move a differing bit to 47
      if (!normFound && (normExt[95 - i] != kPort.sign)) begin
        normCount = 7'(i);
        normFound = 1'b1;
      end
    end
    // round bit shifts up with the coefficient
    normShifted = normExt << normCount;
    normExp = 13'(kPort.expo) - $signed({6'h00, normCount});
    normWord = pack_word(kPort.sign, normExp, normShifted[95:48]);
  end

  // floating add/subtract: no normalization, operands taken as they come
  always_comb begin
    jExp = 13'(jPort.expo);
    kExp = 13'(kPort.expo);
    jLarger = (jExp >= kExp);
    expMax = jLarger ? jExp : kExp;
    expDiff = jLarger ? 13'(jExp - kExp) : 13'(kExp - jExp);
    alignJ = {jPort.coef[49], jPort.coef, 48'h000000000000};
    alignK = {kPort.coef[49], kPort.coef, 48'h000000000000};
    // smaller exponent coefficient moves right; huge gaps leave sign
    shiftJ = jLarger ? alignJ : (alignJ >>> expDiff);
    shiftK = jLarger ? (alignK >>> expDiff) : alignK;
    if (opCode == OP_FLOAT_DIFF) begin
      sumRaw = shiftJ - shiftK;
    end else begin
      sumRaw = shiftJ + shiftK;
    end
    // magnitude of 2^96 or more no longer fits the coefficient
    sumOverflow = (sumRaw[98:96] != {3{sumRaw[98]}});
    sumAdj = sumOverflow ? (sumRaw >>> 1) : sumRaw;
    expRes = expMax + $signed({12'h000, sumOverflow});
    // back to ones complement for packing
    sumOnes = sumAdj[98] ? (sumAdj - 99'sh1) : sumAdj;
    // leading zeros are kept; normalize is a separate op
    singleWord = pack_word(sumOnes[98], expRes, sumOnes[95:48]);
    doubleWord = pack_word(sumOnes[98], expRes - 13'(DOUBLE_EXP_ADJ),
                           sumOnes[47:0]);
  end

  // next state: results hold, strobes and flags are one-cycle pulses
  always_comb begin
    stNext = stReg;
    stNext.resultValid    = 1'b0;
    stNext.indexWrite     = 1'b0;
    stNext.infiniteExit   = 1'b0;
    stNext.indefiniteExit = 1'b0;
    if (issueValid) begin
      case (opCode)
        OP_ROUND_NORM: begin
          stNext.resultValid = 1'b1;
          stNext.indexWrite  = 1'b1;
          if (kSpecial) begin
            // no shift on special operands
            stNext.destWord   = secondSourceWord;
            stNext.indexCount = INDEX_RESET;
          end else begin
            stNext.destWord   = normWord;
            stNext.indexCount = 18'(normCount);
          end
          stNext.infiniteExit   = kPort.isInf;
          stNext.indefiniteExit = kPort.isIndef;
        end
        OP_UNPACK: begin
          stNext.resultValid = 1'b1;
          stNext.indexWrite  = 1'b1;
          stNext.destWord = {{TOP_W{kPort.sign}}, secondSourceWord[47:0]};
          stNext.indexCount = {{7{kPort.expOnes[EXP_SIGN_POS]}},
                               kPort.expOnes};
        end
        OP_PACK: begin
          stNext.resultValid = 1'b1;
          // sign and coefficient copied straight through
          stNext.destWord[SIGN_POS] = secondSourceWord[SIGN_POS];
          stNext.destWord[47:0]     = secondSourceWord[47:0];
          stNext.destWord[EXP_MSB:EXP_LSB] =
            {~indexSource[EXP_SIGN_POS], indexSource[9:0]}
            ^ {EXP_W{secondSourceWord[SIGN_POS]}};
        end
        OP_FLOAT_SUM, OP_FLOAT_DIFF: begin
          stNext.resultValid = 1'b1;
          stNext.destWord    = singleWord;
          stNext.infiniteExit   = jPort.isInf || kPort.isInf;
          stNext.indefiniteExit = jPort.isIndef || kPort.isIndef;
        end
        OP_DOUBLE_SUM: begin
          stNext.resultValid = 1'b1;
          stNext.destWord    = doubleWord;
          stNext.infiniteExit   = jPort.isInf || kPort.isInf;
          stNext.indefiniteExit = jPort.isIndef || kPort.isIndef;
        end
        default: begin
          // codes outside this unit are ignored
          stNext.resultValid = 1'b0;
        end
      endcase
    end
  end

  // state register; no reset is defined for the unit, a clean one is given
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stReg <= '{resultValid: 1'b0, destWord: DEST_RESET,
                 indexCount: INDEX_RESET, indexWrite: 1'b0,
                 infiniteExit: 1'b0, indefiniteExit: 1'b0};
    end else begin
      stReg <= stNext;
    end
  end

  // outputs straight from the state flops
  assign resultValid    = stReg.resultValid;
  assign destWord       = stReg.destWord;
  assign indexCount     = stReg.indexCount;
  assign indexWrite     = stReg.indexWrite;
  assign infiniteExit   = stReg.infiniteExit;
  assign indefiniteExit = stReg.indefiniteExit;

  // checks on the registered results
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  property p_decode_latency;
    issueValid && (opCode inside {6'h15, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1A})
      |=> resultValid;
  endproperty
  a_decode_latency: assert property (p_decode_latency)
    else $error("decoded op gave no result strobe");

  property p_unpack_coef;
    issueUnpack |=> destWord == {{12{$past(secondSourceWord[59])}},
                                 $past(secondSourceWord[47:0])};
  endproperty
  a_unpack_coef: assert property (p_unpack_coef)
    else $error("unpack coefficient wrong");

  // negative coefficient with the field complemented: exponent +28
  property p_unpack_index;
    issueUnpack && (secondSourceWord[59:48] == 12'hBE3)
      |=> indexWrite && (indexCount == 18'h0001C);
  endproperty
  a_unpack_index: assert property (p_unpack_index)
    else $error("unpack exponent wrong");

  property p_pack_copy;
    issuePack |=> destWord[59] == $past(secondSourceWord[59])
                  && destWord[47:0] == $past(secondSourceWord[47:0]);
  endproperty
  a_pack_copy: assert property (p_pack_copy)
    else $error("pack sign or coefficient wrong");

  property p_pack_exp;
    issuePack && (indexSource[10:0] == 11'h7E3) && secondSourceWord[59]
      |=> destWord[58:48] == 11'h41C;
  endproperty
  a_pack_exp: assert property (p_pack_exp)
    else $error("pack exponent field wrong");

  property p_norm_special;
    issueNorm && kSpecial
      |=> destWord == $past(secondSourceWord) && indexCount == 18'h00000;
  endproperty
  a_norm_special: assert property (p_norm_special)
    else $error("special operand was shifted");

  property p_norm_flag;
    issueNorm && kPort.isIndef |=> indefiniteExit && resultValid && indexWrite;
  endproperty
  a_norm_flag: assert property (p_norm_flag)
    else $error("indefinite exit flag not raised");

  property p_norm_result;
    issueNorm && !kSpecial |=> destWord[47] != destWord[59] && indexCount <= 18'h00030;
  endproperty
  a_norm_result: assert property (p_norm_result)
    else $error("normalized word not normalized");

  property p_sum_flags;
    issueAdd && (jPort.isInf || kPort.isInf) |=> infiniteExit && resultValid;
  endproperty
  a_sum_flags: assert property (p_sum_flags)
    else $error("add infinite exit flag missing");

  // finite operands must leave both exit flags quiet
  property p_clean_add;
    issueAdd && !jPort.isInf && !kPort.isInf && !jPort.isIndef && !kPort.isIndef
      |=> resultValid && !infiniteExit && !indefiniteExit && !indexWrite;
  endproperty
  a_clean_add: assert property (p_clean_add)
    else $error("add raised a flag on finite operands");

  // ordinary round-normalize writes the count, no flags
  property p_norm_strobes;
    issueNorm && !kSpecial |=> indexWrite && !infiniteExit && !indefiniteExit;
  endproperty
  a_norm_strobes: assert property (p_norm_strobes)
    else $error("round-normalize count strobe wrong");

  // pack leaves the index result untouched
  property p_pack_hold;
    issuePack |=> resultValid && !indexWrite && $stable(indexCount);
  endproperty
  a_pack_hold: assert property (p_pack_hold)
    else $error("pack disturbed the index result");

  // codes outside this unit change nothing at all
  property p_refused;
    issueValid && !(opCode inside {6'h15, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1A})
      |=> !resultValid && !indexWrite && $stable(destWord) && $stable(indexCount);
  endproperty
  a_refused: assert property (p_refused)
    else $error("foreign opcode changed a result");

  c_unpack:   cover property (issueUnpack ##1 resultValid);
  c_norm_sp:  cover property (issueNorm && kSpecial ##1 infiniteExit);
  c_overflow: cover property (issueAdd && sumOverflow ##1 resultValid);
  c_double:   cover property (issueValid && opCode == 6'h1A ##1 resultValid);

endmodule

//--- tb/float_issue_model.sv
// partner model: instruction issue side that feeds operands to the float unit
`timescale 1ns/1ps
module float_issue_model import float_unit_pkg::*; (
  output logic        issueValid,       // one-cycle operation request
  output logic [5:0]  opCode,           // operation selector
  output logic [59:0] firstSourceWord,  // first operand word
  output logic [59:0] secondSourceWord, // second operand word
  output logic [17:0] indexSource       // index operand for pack
);
  // quiet lines at time zero
  initial begin
    issueValid = 1'b0;
    opCode = 6'h00;
    firstSourceWord = 60'h000000000000000;
    secondSourceWord = 60'h000000000000000;
    indexSource = 18'h00000;
  end

  // caller runs this just after a falling edge; held for one rising edge
  task automatic drive(input logic [5:0] op, input logic [59:0] a, input logic [59:0] b, input logic [17:0] idx);
    issueValid = 1'b1;
    opCode = op;
    firstSourceWord = a;
    secondSourceWord = b;
    indexSource = idx;
  endtask

  // released lines flip so a stale operand can never look valid
  task automatic release_bus();
    issueValid = 1'b0;
    opCode = ~opCode;
    firstSourceWord = ~firstSourceWord;
    secondSourceWord = ~secondSourceWord;
    indexSource = ~indexSource;
  endtask
endmodule

//--- tb/float_unit_tb.sv
// testbench: scenarios for the float normalize, pack and add unit
`timescale 1ns/1ps
module float_unit_tb import float_unit_pkg::*; ;
  logic        core_clk;          // 20 MHz clock
  logic        nrst;              // active-low reset
  logic        issueValid;        // request from partner
  logic [5:0]  opCode;            // operation code
  logic [59:0] firstSourceWord;   // first operand
  logic [59:0] secondSourceWord;  // second operand
  logic [17:0] indexSource;       // pack exponent source
  logic        resultValid;       // result strobe
  logic [59:0] destWord;          // result word
  logic [17:0] indexCount;        // index result
  logic        indexWrite;        // index strobe
  logic        infiniteExit;      // infinite flag
  logic        indefiniteExit;    // indefinite flag
  int          mismatches;        // failed comparisons
  int          comparisons;       // all comparisons
  logic [17:0] lastIdx;           // index value the unit should hold

  // floating words and their unpacked forms, all four sign combinations
  logic [59:0] fltW [4] = '{60'h41C9406DB40003F, 60'h3E39406DB40003F, 60'hBE36BF924BFFFC0, 60'hC1C6BF924BFFFC0};
  logic [59:0] intW [4] = '{60'h0009406DB40003F, 60'h0009406DB40003F, 60'hFFF6BF924BFFFC0, 60'hFFF6BF924BFFFC0};
  logic [17:0] expW [4] = '{18'h0001C, 18'h3FFE3, 18'h0001C, 18'h3FFE3};

  float_issue_model issuer (
    .issueValid       (issueValid),
    .opCode           (opCode),
    .firstSourceWord  (firstSourceWord),
    .secondSourceWord (secondSourceWord),
    .indexSource      (indexSource)
  );

  float_unit DUT (
    .core_clk         (core_clk),
    .nrst             (nrst),
    .issueValid       (issueValid),
    .opCode           (opCode),
    .firstSourceWord  (firstSourceWord),
    .secondSourceWord (secondSourceWord),
    .indexSource      (indexSource),
    .resultValid      (resultValid),
    .destWord         (destWord),
    .indexCount       (indexCount),
    .indexWrite       (indexWrite),
    .infiniteExit     (infiniteExit),
    .indefiniteExit   (indefiniteExit)
  );

  // free-running clock, 50 ns period
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // verdict and end of run, the only exit
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // compare tasks, one per result width
  task automatic cmp_word(input string name, input logic [59:0] e, input logic [59:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic cmp_index(input string name, input logic [17:0] e, input logic [17:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic cmp_bit(input string name, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %b seen %b", name, e, g);
    end
  endtask

  // strobes and index after an op; index holds unless written
  task automatic check_flags(input logic iw, input logic [17:0] x, input logic inf, input logic ind);
    if (iw) begin
      lastIdx = x;
    end
    cmp_bit("resultValid", 1'b1, resultValid);
    cmp_bit("indexWrite", iw, indexWrite);
    cmp_index("indexCount", lastIdx, indexCount);
    cmp_bit("infiniteExit", inf, infiniteExit);
    cmp_bit("indefiniteExit", ind, indefiniteExit);
  endtask

  // issue now (just after a falling edge), judge one cycle later
  task automatic op_check(input logic [5:0] op, input logic [59:0] a, input logic [59:0] b, input logic [17:0] idx,
                          input logic [59:0] d, input logic [17:0] x, input logic iw, input logic inf, input logic ind);
    issuer.drive(op, a, b, idx);
    @(negedge core_clk);
    cmp_word("destWord", d, destWord);
    check_flags(iw, x, inf, ind);
  endtask

  // release and confirm the strobes lasted one cycle only
  task automatic idle_check();
    issuer.release_bus();
    @(negedge core_clk);
    cmp_bit("resultValid idle", 1'b0, resultValid);
    cmp_bit("indexWrite idle", 1'b0, indexWrite);
  endtask

  // both round-normalize examples back to back
  task automatic test_round_norm();
    @(negedge core_clk);
    op_check(OP_ROUND_NORM, 60'h0, 60'h41C027D400004B2, 18'h0, 60'h4169F5000012CA0, 18'h00006, 1, 0, 0);
    op_check(OP_ROUND_NORM, 60'h0, 60'hBE3FD82BFFFFB4D, 18'h0, 60'hBE960AFFFFED35F, 18'h00006, 1, 0, 0);
    idle_check();
  endtask

  // every infinite and indefinite top pattern: copied, no shift
  task automatic test_round_special();
    logic [11:0] tops [4] = '{TOP_INF_POS, TOP_INF_NEG, TOP_INDEF_POS, TOP_INDEF_NEG};
    @(negedge core_clk);
    for (int i = 0; i < 4; i++) begin
      op_check(OP_ROUND_NORM, 60'h0, {tops[i], 48'h000000000123}, 18'h0, {tops[i], 48'h000000000123},
               18'h00000, 1, i < 2, i >= 2);
    end
    idle_check();
  endtask

  // unpack four words, then pack them back; pack leaves index alone
  task automatic test_unpack_pack();
    @(negedge core_clk);
    for (int i = 0; i < 4; i++) begin
      op_check(OP_UNPACK, 60'h0, fltW[i], 18'h0, intW[i], expW[i], 1, 0, 0);
    end
    for (int i = 0; i < 4; i++) begin
      op_check(OP_PACK, 60'h0, intW[i], expW[i], fltW[i], 18'h0, 0, 0, 0);
    end
    idle_check();
  endtask

  // single sum and difference: alignment, overflow, leading zeros, negative
  task automatic test_sum_diff();
    @(negedge core_clk);
    op_check(OP_FLOAT_SUM, 60'h401000000000004, 60'h400000000000008, 18'h0, 60'h401000000000008, 18'h0, 0, 0, 0);
    op_check(OP_FLOAT_SUM, 60'h400800000000000, 60'h400800000000000, 18'h0, 60'h401800000000000, 18'h0, 0, 0, 0);
    op_check(OP_FLOAT_SUM, 60'h431000000000001, 60'h430000000000001, 18'h0, 60'h431000000000001, 18'h0, 0, 0, 0);
    op_check(OP_FLOAT_DIFF, 60'h400000000000003, 60'h400000000000001, 18'h0, 60'h400000000000002, 18'h0, 0, 0, 0);
    op_check(OP_FLOAT_DIFF, 60'h400000000000001, 60'h400000000000003, 18'h0, 60'hBFFFFFFFFFFFFFD, 18'h0, 0, 0, 0);
    idle_check();
  endtask

  // double sum keeps the lower half, exponent less 48
  task automatic test_double();
    @(negedge core_clk);
    op_check(OP_DOUBLE_SUM, 60'h431000000000001, 60'h430000000000001, 18'h0, 60'h401800000000000, 18'h0, 0, 0, 0);
    idle_check();
  endtask

  // exit flags on special operands for all three add forms
  task automatic test_special_add();
    logic [5:0] ops [3] = '{OP_FLOAT_SUM, OP_FLOAT_DIFF, OP_DOUBLE_SUM};
    @(negedge core_clk);
    for (int i = 0; i < 3; i++) begin
      issuer.drive(ops[i], 60'h7FF000000000001, 60'h400000000000001, 18'h0);
      @(negedge core_clk);
      check_flags(0, 18'h0, 1, 0);
      issuer.drive(ops[i], 60'h400000000000001, 60'hC00000000000001, 18'h0);
      @(negedge core_clk);
      check_flags(0, 18'h0, 0, 1);
      issuer.drive(ops[i], 60'h7FF000000000001, 60'h3FF000000000001, 18'h0);
      @(negedge core_clk);
      check_flags(0, 18'h0, 1, 1);
    end
    idle_check();
  endtask

  // codes outside the set are ignored and disturb nothing
  task automatic test_refused();
    logic [59:0] held;
    held = destWord;
    @(negedge core_clk);
    issuer.drive(6'h14, 60'h400000000000001, 60'h400000000000001, 18'h00005);
    @(negedge core_clk);
    issuer.drive(6'h1B, 60'h400000000000001, 60'h400000000000001, 18'h00005);
    @(negedge core_clk);
    cmp_bit("resultValid refused", 1'b0, resultValid);
    cmp_word("destWord refused", held, destWord);
    cmp_index("indexCount refused", lastIdx, indexCount);
    idle_check();
  endtask

  // a hang counts as a mismatch and ends the run
  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    $display("unexpected timeout of the scenario sequence");
    finish_test();
  end

  // main sequence: reset, then scenarios
  initial begin
    mismatches = 0;
    comparisons = 0;
    lastIdx = INDEX_RESET;
    nrst = 1'b0;
    repeat (3) @(negedge core_clk);
    cmp_bit("resultValid reset", 1'b0, resultValid);
    cmp_word("destWord reset", DEST_RESET, destWord);
    cmp_index("indexCount reset", INDEX_RESET, indexCount);
    nrst = 1'b1;
    test_round_norm();
    test_round_special();
    test_unpack_pack();
    test_sum_diff();
    test_double();
    test_special_add();
    test_refused();
    finish_test();
  end
endmodule
